/* File: src/tmpfmt_pkg.sv */
// Purpose: Shared constants for the temperature result formatter.
// Assumes: Raw conversion samples arrive as signed counts of 0.0625 degree steps.
// Notes:   Limit reset values are plain defaults; the bench checks them as 4b00 and 5000 after reset.
package tmpfmt_pkg;
    localparam int          CODE_W     = 12;
    localparam int          REG_W      = 16;
    localparam int          PAD_W      = 4;
    localparam int          BYTE_W     = 8;
    localparam logic [11:0] CODE_MAX   = 12'h7ff;
    localparam logic [11:0] CODE_MIN   = 12'h800;
    localparam logic [15:0] RESULT_RST = 16'h0000;
    localparam logic [15:0] TLOW_RST   = 16'h4b00;
    localparam logic [15:0] THIGH_RST  = 16'h5000;
    localparam logic [3:0]  PAD_ZERO   = 4'h0;
    localparam logic        SEL_LOW    = 1'b0;
    localparam logic        SEL_HIGH   = 1'b1;
    localparam logic        BYTE_MSB   = 1'b0;
    localparam logic        BYTE_LSB   = 1'b1;
endpackage

/* File: src/tmpfmt_conv_if.sv */
// Purpose: Carries raw samples to the encoder and codes back to the register logic.
// Assumes: One clock domain.
// Notes:   Raw is a signed count of 0.0625 degree steps.
`timescale 1ns/10ps
interface tmpfmt_conv_if #(
    parameter int RAW_W = 16
);
    logic signed [RAW_W-1:0] raw;
    logic                    rawValid;
    logic [11:0]             code;
    logic                    codeValid;

    modport enc (input raw, input rawValid, output code, output codeValid);
    modport regs (output raw, output rawValid, input code, input codeValid);
endinterface

/* File: src/tmpfmt_encode.sv */
// Purpose: Turns a raw signed sample into a saturated 12-bit two's complement code.
// Assumes: RAW_W is at least 13 so that out-of-range values can be seen.
// Notes:   One cycle of latency; codeValid pulses one cycle after rawValid.
`timescale 1ns/10ps
module tmpfmt_encode #(
    parameter int RAW_W = 16
) (
    input  wire logic clk,
    input  wire logic rst,
    tmpfmt_conv_if.enc conv
);
    localparam logic signed [RAW_W-1:0] satHi = {{(RAW_W-12){1'b0}}, tmpfmt_pkg::CODE_MAX};
    localparam logic signed [RAW_W-1:0] satLo = {{(RAW_W-12){1'b1}}, tmpfmt_pkg::CODE_MIN};

    // Clamp before truncating so 128 degrees cannot wrap into a negative code
    wire logic        overHi = conv.raw > satHi;
    wire logic        underLo = conv.raw < satLo;
    wire logic [11:0] next_code = overHi ? tmpfmt_pkg::CODE_MAX :
                                  underLo ? tmpfmt_pkg::CODE_MIN :
                                  conv.raw[11:0];

    // Code register
    always_ff @(posedge clk) begin
        if (rst) begin
            conv.code      <= 12'h000;
            conv.codeValid <= 1'b0;
        end else begin
            conv.codeValid <= conv.rawValid;
            if (conv.rawValid) begin
                conv.code <= next_code;
            end
        end
    end

    // Saturation at both ends of the code span
    a_sat_high: assert property (@(posedge clk) disable iff (rst)
        conv.rawValid && conv.raw > satHi |=> conv.code == tmpfmt_pkg::CODE_MAX)
        else $error("Positive overrange not saturated to 7ff");

    a_sat_low: assert property (@(posedge clk) disable iff (rst)
        conv.rawValid && conv.raw < satLo |=> conv.code == tmpfmt_pkg::CODE_MIN)
        else $error("Negative overrange not saturated to 800");

    // Sign bit survives the clamp; published reference points
    a_code_sign: assert property (@(posedge clk) disable iff (rst)
        conv.rawValid |=> conv.code[11] == $past(conv.raw[RAW_W-1]))
        else $error("Code sign bit differs from sample sign");

    a_ref_points: assert property (@(posedge clk) disable iff (rst)
        conv.rawValid && conv.raw == -RAW_W'(400) |=> conv.code == 12'he70)
        else $error("Minus 25 degrees did not encode as e70");

    a_ref_quarter: assert property (@(posedge clk) disable iff (rst)
        conv.rawValid && conv.raw == -RAW_W'(4) |=> conv.code == 12'hffc)
        else $error("Minus 0.25 degrees did not encode as ffc");
endmodule

/* File: src/tmpfmt_result.sv */
// Purpose: Read-only temperature result register with byte read port and limits.
// Assumes: The serial engine outside turns bus bytes into the strobes below.
// Notes:   A read snapshots the result so both bytes come from one conversion.
`timescale 1ns/10ps
module tmpfmt_result #(
    parameter int RAW_W = 16
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              convDone,
    input  wire logic signed [RAW_W-1:0] convRaw,
    input  wire logic              rdByte,
    input  wire logic              rdFirst,
    input  wire logic              wrResult,
    input  wire logic [15:0]       wrData,
    input  wire logic              limWr,
    input  wire logic              limSel,
    output      logic [15:0]       tempResult,
    output      logic [15:0]       limitLow,
    output      logic [15:0]       limitHigh,
    output      logic [7:0]        rdData,
    output      logic              rdValid,
    output      logic              resultFresh,
    output      logic              atOrAboveHigh,
    output      logic              belowLow
);
    tmpfmt_conv_if #(.RAW_W(RAW_W)) conv ();

    tmpfmt_encode #(.RAW_W(RAW_W)) uEncode (
        .clk  (clk),
        .rst  (rst),
        .conv (conv)
    );

    logic [15:0] snapshot;
    logic        byteIdx;

    // Signed code held in the upper twelve bits of a register word
    function automatic logic signed [11:0] codeOf(input logic [15:0] word);
        return signed'(word[15:4]);
    endfunction

    // Raw sample feeds the encoder
    assign conv.raw      = convRaw;
    assign conv.rawValid = convDone;

    // Next values for the result word, limits and flags
    wire logic [15:0] next_result  = {conv.code, tmpfmt_pkg::PAD_ZERO};
    wire logic        next_high    = signed'(conv.code) >= codeOf(limitHigh);
    wire logic        next_low     = signed'(conv.code) < codeOf(limitLow);
    wire logic [15:0] next_limit   = {wrData[15:4], tmpfmt_pkg::PAD_ZERO};
    wire logic [15:0] readWord     = rdFirst ? tempResult : snapshot;
    wire logic        readIdx      = rdFirst ? tmpfmt_pkg::BYTE_MSB : byteIdx;
    wire logic [7:0]  next_rdData  = (readIdx == tmpfmt_pkg::BYTE_MSB) ?
                                     readWord[15:8] : readWord[7:0];

    // Result register; wrResult is deliberately not consulted here
    always_ff @(posedge clk) begin
        if (rst) begin
            tempResult    <= tmpfmt_pkg::RESULT_RST;
            resultFresh   <= 1'b0;
            atOrAboveHigh <= 1'b0;
            belowLow      <= 1'b0;
        end else begin
            resultFresh <= conv.codeValid;
            if (conv.codeValid) begin
                tempResult    <= next_result;
                atOrAboveHigh <= next_high;
                belowLow      <= next_low;
            end
        end
    end

    // Limit registers; low nibble forced to zero to match the result format
    always_ff @(posedge clk) begin
        if (rst) begin
            limitLow  <= tmpfmt_pkg::TLOW_RST;
            limitHigh <= tmpfmt_pkg::THIGH_RST;
        end else if (limWr) begin
            if (limSel == tmpfmt_pkg::SEL_HIGH) begin
                limitHigh <= next_limit;
            end else begin
                limitLow <= next_limit;
            end
        end
    end

    // Byte read port; stopping after one byte leaves nothing to clean up
    always_ff @(posedge clk) begin
        if (rst) begin
            snapshot <= tmpfmt_pkg::RESULT_RST;
            byteIdx  <= tmpfmt_pkg::BYTE_MSB;
            rdData   <= 8'h00;
            rdValid  <= 1'b0;
        end else begin
            rdValid <= rdByte;
            if (rdByte) begin
                rdData  <= next_rdData;
                byteIdx <= ~readIdx;
                if (rdFirst) begin
                    snapshot <= tempResult;
                end
            end
        end
    end

    // Result word: padding, update path and immunity to bus writes
    a_left_just: assert property (@(posedge clk) disable iff (rst)
        tempResult[3:0] == tmpfmt_pkg::PAD_ZERO && limitLow[3:0] == tmpfmt_pkg::PAD_ZERO
        && limitHigh[3:0] == tmpfmt_pkg::PAD_ZERO)
        else $error("Low nibble of a register word is not zero");

    // Past code, so a conversion on the very next cycle cannot confuse it
    a_conv_update: assert property (@(posedge clk) disable iff (rst)
        convDone |=> ##1 (resultFresh && tempResult[15:4] == $past(conv.code)))
        else $error("Conversion did not reach the result register");

    a_fresh_pulse: assert property (@(posedge clk) disable iff (rst)
        conv.codeValid
        |=> resultFresh && tempResult == {$past(conv.code), tmpfmt_pkg::PAD_ZERO})
        else $error("New code was not loaded into the result word");

    a_result_hold: assert property (@(posedge clk) disable iff (rst)
        !conv.codeValid |=> $stable(tempResult) && !resultFresh)
        else $error("Result word moved without a conversion");

    a_write_ignored: assert property (@(posedge clk) disable iff (rst)
        wrResult && !conv.codeValid |=> $stable(tempResult))
        else $error("Bus write changed the result register");

    a_ref_25: assert property (@(posedge clk) disable iff (rst)
        convDone && convRaw == RAW_W'(400) |=> ##1 tempResult == 16'h1900)
        else $error("25 degrees did not read as 1900");

    // Byte read port: order, answer timing and restart after a short read
    a_msb_first: assert property (@(posedge clk) disable iff (rst)
        rdByte && rdFirst |=> rdValid && rdData == $past(tempResult[15:8]))
        else $error("First byte of a read is not the upper byte");

    a_lsb_second: assert property (@(posedge clk) disable iff (rst)
        rdByte && rdFirst ##1 (rdByte && !rdFirst)
        |=> rdValid && rdData == $past(tempResult[7:0], 2))
        else $error("Second byte of a read is not the lower byte");

    // A third byte wraps back to the upper byte of the same snapshot
    a_third_byte: assert property (@(posedge clk) disable iff (rst)
        rdByte && rdFirst ##1 (rdByte && !rdFirst) [*2]
        |=> rdValid && rdData == $past(tempResult[15:8], 3))
        else $error("Third byte of a read is not the snapshot upper byte");

    a_rd_answer: assert property (@(posedge clk) disable iff (rst)
        rdByte |=> rdValid)
        else $error("Byte request got no answer");

    a_rd_idle: assert property (@(posedge clk) disable iff (rst)
        !rdByte |=> !rdValid && $stable(rdData))
        else $error("Read port answered without a request");

    a_idx_toggle: assert property (@(posedge clk) disable iff (rst)
        rdByte && !rdFirst |=> byteIdx == ~$past(byteIdx))
        else $error("Byte index did not alternate");

    a_snap_take: assert property (@(posedge clk) disable iff (rst)
        rdByte && rdFirst |=> snapshot == $past(tempResult))
        else $error("Snapshot not taken at the first byte");

    // Snapshot must not follow a conversion between the two bytes
    a_snap_hold: assert property (@(posedge clk) disable iff (rst)
        !(rdByte && rdFirst) |=> $stable(snapshot))
        else $error("Snapshot changed inside a read");

    a_short_read: assert property (@(posedge clk) disable iff (rst)
        rdByte && rdFirst ##1 (!rdByte) [*2] ##1 (rdByte && rdFirst)
        |=> rdData == $past(tempResult[15:8]))
        else $error("Read after a one-byte read did not restart at the upper byte");

    a_restart_idx: assert property (@(posedge clk) disable iff (rst)
        rdByte && rdFirst |=> byteIdx == tmpfmt_pkg::BYTE_LSB)
        else $error("First byte did not point the next one at the lower byte");

    // Limits: write path and comparison against each new result
    a_limit_cmp: assert property (@(posedge clk) disable iff (rst)
        resultFresh |-> atOrAboveHigh == (codeOf(tempResult) >= codeOf($past(limitHigh)))
                        && belowLow == (codeOf(tempResult) < codeOf($past(limitLow))))
        else $error("Limit flags disagree with the new result");

    a_high_write: assert property (@(posedge clk) disable iff (rst)
        limWr && limSel == tmpfmt_pkg::SEL_HIGH
        |=> limitHigh == {$past(wrData[15:4]), tmpfmt_pkg::PAD_ZERO})
        else $error("High limit write did not land");

    a_low_write: assert property (@(posedge clk) disable iff (rst)
        limWr && limSel == tmpfmt_pkg::SEL_LOW
        |=> limitLow == {$past(wrData[15:4]), tmpfmt_pkg::PAD_ZERO})
        else $error("Low limit write did not land");

    a_high_untouched: assert property (@(posedge clk) disable iff (rst)
        limWr && limSel == tmpfmt_pkg::SEL_LOW |=> $stable(limitHigh))
        else $error("Low limit write disturbed the high limit");

    a_limit_hold: assert property (@(posedge clk) disable iff (rst)
        !limWr |=> $stable(limitHigh) && $stable(limitLow))
        else $error("Limit moved without a limit write");

    // Flags are levels; they only move with a new result
    a_flag_hold: assert property (@(posedge clk) disable iff (rst)
        !conv.codeValid |=> $stable(atOrAboveHigh) && $stable(belowLow))
        else $error("Limit flag moved without a conversion");
endmodule

/* File: verif/tmpfmt_reader.sv */
// Purpose: Bus-side reader that pulls result bytes from the formatter.
// Assumes: Strobes change on the falling clock edge only.
// Notes:   Byte count is the caller's; one byte makes a short read.
`timescale 1ns/10ps
module tmpfmt_reader (
    input  wire logic       clk,
    output      logic       rdByte,
    output      logic       rdFirst,
    input  wire logic [7:0] rdData,
    input  wire logic       rdValid
);
    initial begin
        rdByte  = 1'b0;
        rdFirst = 1'b0;
    end
    // Back-to-back requests, first byte flagged, bytes shift in MSB first
    // Stopping after one byte is legal; the next read restarts
    task automatic read_reg(input int n, output logic [15:0] w, output logic ok);
        w  = 16'h0000;
        ok = 1'b1;
        for (int i = 0; i < n; i++) begin
            rdByte  = 1'b1;
            rdFirst = (i == 0);
            @(negedge clk);
            ok = ok & (rdValid === 1'b1);
            w  = {w[7:0], rdData};
        end
        rdByte  = 1'b0;
        rdFirst = 1'b0;
        // Two idle cycles so back-to-back calls never retoggle a strobe in one step
        repeat (2) @(negedge clk);
    endtask
endmodule

/* File: verif/temperature_result_format_bench.sv */
// Purpose: Self-checking bench for the temperature result register.
// Assumes: Inputs change on the falling edge; byte answers land one rising edge on, results two.
// Notes:   Expected codes come from a clamp written here, not the design.
`timescale 1ns/10ps
module temperature_result_format_bench;
    logic               clk, rst, convDone, rdByte, rdFirst, wrResult, limWr, limSel;
    logic               rdValid, resultFresh, atOrAboveHigh, belowLow, ok;
    logic signed [15:0] convRaw;
    logic [15:0]        wrData, tempResult, limitLow, limitHigh, word;
    logic [7:0]         rdData;
    int                 fails;
    int                 checks_done;
    int                 temps [8] = '{400, -4, -400, 2048, 2047, -880, 4, -3000};

    tmpfmt_result #(.RAW_W(16)) dut (
        .clk(clk), .rst(rst), .convDone(convDone), .convRaw(convRaw),
        .rdByte(rdByte), .rdFirst(rdFirst), .wrResult(wrResult), .wrData(wrData),
        .limWr(limWr), .limSel(limSel), .tempResult(tempResult),
        .limitLow(limitLow), .limitHigh(limitHigh), .rdData(rdData),
        .rdValid(rdValid), .resultFresh(resultFresh),
        .atOrAboveHigh(atOrAboveHigh), .belowLow(belowLow)
    );
    tmpfmt_reader rdr (
        .clk(clk), .rdByte(rdByte), .rdFirst(rdFirst), .rdData(rdData), .rdValid(rdValid)
    );

    // Compare, count, report
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Saturate to the 12-bit signed span, then pad the low nibble
    function automatic logic [15:0] expect_word(input int t);
        int c;
        c = t > 2047 ? 2047 : (t < -2048 ? -2048 : t);
        return {c[11:0], 4'h0};
    endfunction
    // One conversion pulse, checked where the update lands
    task automatic convert(input int t);
        convDone = 1'b1;
        convRaw  = 16'(t);
        @(negedge clk);
        convDone = 1'b0;
        @(negedge clk);
        chk({15'h0000, resultFresh}, 16'h0001);
        chk(tempResult, expect_word(t));
    endtask
    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Generous bound; the tests need about 62 cycles
    initial begin
        #20000;
        fails++;
        report_and_stop();
    end
    initial begin
        {convDone, convRaw, wrResult, wrData, limWr, limSel} = '0;
        rst = 1'b1;
        repeat (20) @(negedge clk);
        chk(tempResult, 16'h0000);
        chk(limitLow, 16'h4b00);
        chk(limitHigh, 16'h5000);
        rst = 1'b0;
        @(negedge clk);
        $display("Test reset done");
        foreach (temps[i]) begin
            convert(temps[i]);
        end
        $display("Test encode done");
        convert(-400);
        rdr.read_reg(1, word, ok);
        chk(word, 16'h00e7);
        chk({15'h0000, ok}, 16'h0001);
        rdr.read_reg(2, word, ok);
        chk(word, 16'he700);
        chk({15'h0000, ok}, 16'h0001);
        rdr.read_reg(3, word, ok);
        chk(word, 16'h00e7);
        chk({15'h0000, ok}, 16'h0001);
        $display("Test read done");
        wrResult = 1'b1;
        wrData   = 16'hffff;
        @(negedge clk);
        wrResult = 1'b0;
        repeat (2) @(negedge clk);
        chk(tempResult, 16'he700);
        $display("Test write done");
        limWr  = 1'b1;
        limSel = 1'b1;
        wrData = 16'h190f;
        @(negedge clk);
        limSel = 1'b0;
        wrData = 16'h0000;
        @(negedge clk);
        limWr = 1'b0;
        chk(limitHigh, 16'h1900);
        chk(limitLow, 16'h0000);
        convert(400);
        chk({14'h0000, atOrAboveHigh, belowLow}, 16'h0002);
        convert(-4);
        chk({14'h0000, atOrAboveHigh, belowLow}, 16'h0001);
        convert(0);
        chk({14'h0000, atOrAboveHigh, belowLow}, 16'h0000);
        $display("Test limits done");
        report_and_stop();
    end
endmodule
